// [rtl/lrx_pkg.sv]
package lrx_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices as printed (low byte of the per-channel offset)
  localparam int IDX_IRQ_EN   = 'h27;
  localparam int IDX_SIG_STAT = 'h28;
  localparam int IDX_SIG_EN   = 'h29;
  localparam int IDX_DL_STAT  = 'h2c;
  localparam int IDX_DL_CLR   = 'h2d;
  localparam int IDX_CFG      = 'h2e;

  // byte addresses: one aligned word per register
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = ADDR_W'(IDX_IRQ_EN * 4);
  localparam logic [ADDR_W-1:0] ADDR_SIG_STAT = ADDR_W'(IDX_SIG_STAT * 4);
  localparam logic [ADDR_W-1:0] ADDR_SIG_EN   = ADDR_W'(IDX_SIG_EN * 4);
  localparam logic [ADDR_W-1:0] ADDR_DL_STAT  = ADDR_W'(IDX_DL_STAT * 4);
  localparam logic [ADDR_W-1:0] ADDR_DL_CLR   = ADDR_W'(IDX_DL_CLR * 4);
  localparam logic [ADDR_W-1:0] ADDR_CFG      = ADDR_W'(IDX_CFG * 4);

  // register select decoded from an address
  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_IRQ_EN   = 3'b001,
    SEL_SIG_STAT = 3'b010,
    SEL_SIG_EN   = 3'b011,
    SEL_DL_STAT  = 3'b100,
    SEL_DL_CLR   = 3'b101,
    SEL_CFG      = 3'b110
  } lrx_sel_t;

  // field widths and positions
  localparam int DL_W  = 7;
  localparam int SIG_W = 6;
  localparam int DL_TX_SOT = 6;
  localparam int DL_RX_SOT = 5;
  localparam int DL_TX_EOT = 4;
  localparam int DL_RX_EOT = 3;
  localparam int DL_FCS    = 2;
  localparam int DL_ABORT  = 1;
  localparam int DL_FLAG   = 0;
  localparam int SIG_TX_SOT = 5;
  localparam int SIG_RX_SOT = 4;
  localparam int SIG_TX_EOT = 3;
  localparam int SIG_RX_EOT = 2;
  localparam int SIG_FAIL   = 1;
  localparam int SIG_OVL    = 0;
  localparam int CFG_THR64  = 0;

  // reset values
  localparam logic [DL_W-1:0]  RST_DL_EN    = 7'h00;
  localparam logic [DL_W-1:0]  RST_DL_STAT  = 7'h00;
  localparam logic [SIG_W-1:0] RST_SIG_EN   = 6'h00;
  localparam logic [SIG_W-1:0] RST_SIG_STAT = 6'h00;

  // line and message figures
  localparam logic [7:0] FLAG_OCTET   = 8'h7e;
  localparam logic [2:0] ABORT_RUN    = 3'h7;
  localparam int         CRC_THR_LO   = 32;
  localparam int         CRC_THR_HI   = 64;
  localparam int         MAX_LAPD_LEN = 276;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/lrx_irq.sv]
// Operation
// - fcs error raises interrupt when bit 2 enabled
// - seven ones abort raises interrupt when bit 1 enabled
// - flag octet 0x7e raises interrupt when bit 0 enabled
// - crc failure flag at 32 or 64 bad frames
// - over-length flag when message exceeds 276 bytes
// - signalling flags clear on read and on write
// - bits 5..2 hold start/end flags, 7..6 zero
// - crc failure interrupt gated by signalling enable bit 1
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lrx_irq #(
  parameter int CRC_THR_LO   = lrx_pkg::CRC_THR_LO,
  parameter int CRC_THR_HI   = lrx_pkg::CRC_THR_HI,
  parameter int MAX_LAPD_LEN = lrx_pkg::MAX_LAPD_LEN
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write address
  input  wire logic [lrx_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // axi4-lite write data
  input  wire logic [lrx_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read address
  input  wire logic [lrx_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // axi4-lite read data
  output logic [lrx_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // data link receive bit stream
  input  wire logic                        dl_rx_bit,
  input  wire logic                        dl_rx_bit_valid,
  // data link controller event pulses
  input  wire logic                        dl_fcs_error,
  input  wire logic                        dl_tx_start,
  input  wire logic                        dl_rx_start,
  input  wire logic                        dl_tx_end,
  input  wire logic                        dl_rx_end,
  // signalling controller event pulses
  input  wire logic                        sig_tx_start,
  input  wire logic                        sig_rx_start,
  input  wire logic                        sig_tx_end,
  input  wire logic                        sig_rx_end,
  input  wire logic                        sig_frame_done,
  input  wire logic                        sig_frame_crc_bad,
  // lapd receive byte stream
  input  wire logic                        lapd_rx_msg_start,
  input  wire logic                        lapd_rx_byte,
  // interrupt
  output logic                             irq
);
  import lrx_pkg::*;

  // counter limits at counter width; keep the parameters inside these widths
  localparam logic [6:0] THR_LO  = 7'(CRC_THR_LO);
  localparam logic [6:0] THR_HI  = 7'(CRC_THR_HI);
  localparam logic [8:0] LEN_MAX = 9'(MAX_LAPD_LEN);

  typedef struct packed {
    // write channel: address and data held until both are in
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [DATA_W-1:0] wdata;
    logic              wstrb0;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;

    // read channel
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;

    // software registers
    logic [DL_W-1:0]   dl_en;
    logic [DL_W-1:0]   dl_stat;
    logic [SIG_W-1:0]  sig_en;
    logic [SIG_W-1:0]  sig_stat;
    logic              thr64;

    // line watchers and counters
    logic [7:0]        shift;
    logic [2:0]        ones;
    logic [6:0]        crc_cnt;
    logic [8:0]        len_cnt;

    // interrupt line
    logic              irq;
  } lrx_state_t;

  // reset image: every channel ready, every flag, enable and count clear
  localparam lrx_state_t ST_RST = '{
    aw_held:  1'b0,
    awaddr:   '0,
    w_held:   1'b0,
    wdata:    '0,
    wstrb0:   1'b0,
    awready:  1'b1,
    wready:   1'b1,
    bvalid:   1'b0,
    bresp:    RESP_OKAY,
    arready:  1'b1,
    rvalid:   1'b0,
    rdata:    '0,
    rresp:    RESP_OKAY,
    dl_en:    RST_DL_EN,
    dl_stat:  RST_DL_STAT,
    sig_en:   RST_SIG_EN,
    sig_stat: RST_SIG_STAT,
    thr64:    1'b0,
    shift:    8'h00,
    ones:     3'h0,
    crc_cnt:  7'h00,
    len_cnt:  9'h000,
    irq:      1'b0
  };

  // address decode, shared by the read and write paths
  function automatic lrx_sel_t lrx_decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    // low address bits ignored: one register per aligned word
    w = {a[ADDR_W-1:2], 2'b00};
    case (w)
      ADDR_IRQ_EN:   lrx_decode = SEL_IRQ_EN;
      ADDR_SIG_STAT: lrx_decode = SEL_SIG_STAT;
      ADDR_SIG_EN:   lrx_decode = SEL_SIG_EN;
      ADDR_DL_STAT:  lrx_decode = SEL_DL_STAT;
      ADDR_DL_CLR:   lrx_decode = SEL_DL_CLR;
      ADDR_CFG:      lrx_decode = SEL_CFG;
      default:       lrx_decode = SEL_NONE;
    endcase
  endfunction

  // present and next state
  lrx_state_t q;
  lrx_state_t d;

  // all next-state logic
  always_comb begin
    // events found this cycle
    logic              abort_ev;
    logic              flag_ev;
    logic              fail_ev;
    logic              ovl_ev;

    // watcher and counter helpers
    logic [7:0]        shifted;
    logic [6:0]        thr;
    logic [8:0]        len_base;

    // flag set and clear masks
    logic [DL_W-1:0]   dl_set;
    logic [DL_W-1:0]   dl_clr;
    logic [SIG_W-1:0]  sig_set;
    logic [SIG_W-1:0]  sig_clr;

    // register selects and interrupt terms
    lrx_sel_t          wsel;
    lrx_sel_t          rsel;
    logic              dl_hit;
    logic              sig_hit;

    // defaults: hold every state bit, no event, no clear
    abort_ev = 1'b0;
    flag_ev  = 1'b0;
    fail_ev  = 1'b0;
    ovl_ev   = 1'b0;
    shifted  = {q.shift[6:0], dl_rx_bit};
    thr      = q.thr64 ? THR_HI : THR_LO;
    len_base = lapd_rx_msg_start ? 9'h000 : q.len_cnt;
    dl_set   = '0;
    sig_set  = '0;
    dl_clr   = '0;
    sig_clr  = '0;
    dl_hit   = 1'b0;
    sig_hit  = 1'b0;
    wsel     = lrx_decode(q.awaddr);
    rsel     = lrx_decode(s_axi_araddr);
    d        = q;

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.awaddr  = s_axi_awaddr;
      d.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
      d.wready = 1'b0;
    end

    // write takes effect once both halves are held
    if (q.aw_held && q.w_held && !q.bvalid) begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // enables and config need the low byte lane; a signalling status write always clears
      case (wsel)
        SEL_IRQ_EN:   if (q.wstrb0) d.dl_en = q.wdata[DL_W-1:0];
        SEL_SIG_EN:   if (q.wstrb0) d.sig_en = q.wdata[SIG_W-1:0];
        SEL_CFG:      if (q.wstrb0) d.thr64 = q.wdata[CFG_THR64];
        SEL_DL_CLR:   if (q.wstrb0) dl_clr = q.wdata[DL_W-1:0];
        SEL_SIG_STAT: sig_clr = '1;
        default:      sig_clr = '0;
      endcase
    end
    // readies come back only after the response is taken: one write at a time
    if (q.bvalid && s_axi_bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end

    // read: data sampled at the address handshake, answered next cycle
    if (s_axi_arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      d.rdata   = '0;
      // a signalling status read returns the old flags and clears them on the same edge
      case (rsel)
        SEL_IRQ_EN:   d.rdata[DL_W-1:0] = q.dl_en;
        SEL_SIG_STAT: begin
          d.rdata[SIG_W-1:0] = q.sig_stat;
          sig_clr = '1;
        end
        SEL_SIG_EN:   d.rdata[SIG_W-1:0] = q.sig_en;
        SEL_DL_STAT:  d.rdata[DL_W-1:0] = q.dl_stat;
        SEL_CFG:      d.rdata[CFG_THR64] = q.thr64;
        default:      d.rdata = '0;                                       // clear reg reads zero
      endcase
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end

    // bit stream watcher: run of ones for abort, 8-bit window for the flag
    if (dl_rx_bit_valid) begin
      d.shift = shifted;
      // saturate so a long run of ones reports abort only once
      if (dl_rx_bit) begin
        abort_ev = (q.ones == ABORT_RUN - 3'h1);
        d.ones   = (q.ones == ABORT_RUN) ? q.ones : q.ones + 3'h1;
      end else begin
        d.ones = 3'h0;
      end
      flag_ev = (shifted == FLAG_OCTET);
    end

    // consecutive corrupted frames; a good frame restarts the count
    if (sig_frame_done) begin
      // count restarts on the failure so a further run can fire again
      if (sig_frame_crc_bad) begin
        if (q.crc_cnt + 7'h01 == thr) begin
          fail_ev   = 1'b1;
          d.crc_cnt = 7'h00;
        end else begin
          d.crc_cnt = q.crc_cnt + 7'h01;
        end
      end else begin
        d.crc_cnt = 7'h00;
      end
    end

    // message length; counter stops one past the limit so it flags once
    d.len_cnt = len_base;
    // a start and a byte in one cycle count as the first byte
    if (lapd_rx_byte) begin
      ovl_ev = (len_base == LEN_MAX);
      if (len_base <= LEN_MAX) d.len_cnt = len_base + 9'h001;
    end

    // sticky flags: an event in the clearing cycle survives the clear
    // data link events
    dl_set[DL_TX_SOT] = dl_tx_start;
    dl_set[DL_RX_SOT] = dl_rx_start;
    dl_set[DL_TX_EOT] = dl_tx_end;
    dl_set[DL_RX_EOT] = dl_rx_end;
    dl_set[DL_FCS]    = dl_fcs_error;
    dl_set[DL_ABORT]  = abort_ev;
    dl_set[DL_FLAG]   = flag_ev;

    // signalling events
    sig_set[SIG_TX_SOT] = sig_tx_start;
    sig_set[SIG_RX_SOT] = sig_rx_start;
    sig_set[SIG_TX_EOT] = sig_tx_end;
    sig_set[SIG_RX_EOT] = sig_rx_end;
    sig_set[SIG_FAIL]   = fail_ev;
    sig_set[SIG_OVL]    = ovl_ev;

    // clear first, then set, so the set wins
    d.dl_stat  = (q.dl_stat & ~dl_clr) | dl_set;
    d.sig_stat = (q.sig_stat & ~sig_clr) | sig_set;

    // level interrupt follows the new flags, so it drops with the clear
    dl_hit  = |(d.dl_stat & d.dl_en);
    sig_hit = |(d.sig_stat & d.sig_en);
    d.irq   = dl_hit | sig_hit;
  end

  // single state register, synchronous reset
  // no asynchronous path: reset is sampled like any other input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  // write channel
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;

  // read channel
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;

  // interrupt
  assign irq           = q.irq;

endmodule
`default_nettype wire

// [verification/lrx_irq_props.sv]
`timescale 1ns/1ps
`default_nettype none
module lrx_irq_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // interrupt
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves offered together are taken on one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_resp_time: assert property (s_wr_take |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_rd_resp_time: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data not one cycle after handshake");
  a_aw_refused: assert property (s_wr_take |=> !s_axi_awready [*2])
    else $error("write address accepted while write pending");
  a_ar_refused: assert property (s_rd_take |=> !s_axi_arready)
    else $error("read address accepted while read pending");
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  a_rsv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  a_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_irq_release: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high out of reset");
endmodule
bind lrx_irq lrx_irq_props u_props (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rdata   (s_axi_rdata),
  .irq           (irq)
);
`default_nettype wire

// [verification/lrx_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host software side: one write and one read at a time, waits as long as the slave needs
module lrx_host (
  // clock
  input wire logic         aclk,
  // write channels
  output logic [7:0]       s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_awvalid,
  input wire logic         s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [7:0]       s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  output logic             s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  output logic             s_axi_rready
);
  // registers live in the low byte only
  assign s_axi_wstrb  = 4'h1;
  assign s_axi_awprot = 3'h0;
  assign s_axi_arprot = 3'h0;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} <= '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= '0;
  end
  // each channel released on its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/lrx_irq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lrx_irq_tb;
  import lrx_pkg::*;
  logic aclk, aresetn, dl_rx_bit, dl_rx_bit_valid;
  logic [12:0] ev;
  int mismatches, cmp_count, cyc;
  wire logic [7:0] s_axi_awaddr, s_axi_araddr;
  wire logic [31:0] s_axi_wdata, s_axi_rdata;
  wire logic [2:0] s_axi_awprot, s_axi_arprot;
  wire logic [3:0] s_axi_wstrb;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  lrx_host u_host (.*);
  // short counts keep the threshold and length tests brief
  lrx_irq #(.CRC_THR_LO(4), .CRC_THR_HI(8), .MAX_LAPD_LEN(10)) DUT (.*,
    .dl_fcs_error(ev[0]), .dl_tx_start(ev[1]), .dl_rx_start(ev[2]), .dl_tx_end(ev[3]),
    .dl_rx_end(ev[4]), .sig_tx_start(ev[5]), .sig_rx_start(ev[6]), .sig_tx_end(ev[7]),
    .sig_rx_end(ev[8]), .sig_frame_done(ev[9]), .sig_frame_crc_bad(ev[10]),
    .lapd_rx_msg_start(ev[11]), .lapd_rx_byte(ev[12]));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      summarize;
    end
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e, logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(a, d, r);
    chk("rdata", e, d);
    chk("rresp", 32'(er), 32'(r));
  endtask
  task automatic wc(logic [7:0] a, logic [31:0] v, logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    u_host.wr(a, v, r);
    chk("bresp", 32'(er), 32'(r));
  endtask
  // one-cycle event pulses, a quiet cycle between them
  task automatic pulse(logic [12:0] m, int n);
    repeat (n) begin
      @(posedge aclk) ev <= m;
      @(posedge aclk) ev <= '0;
    end
    #1;
  endtask
  // serial bits, oldest first
  task automatic bits(logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(posedge aclk) dl_rx_bit <= v[i];
      dl_rx_bit_valid <= 1'b1;
    end
    @(posedge aclk) dl_rx_bit_valid <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rc(ADDR_IRQ_EN, 32'h0);
    rc(ADDR_SIG_STAT, 32'h0);
    rc(ADDR_DL_CLR, 32'h0);
    rc(ADDR_CFG, 32'h0);
    rc(8'h00, 32'h0, RESP_SLVERR);
    wc(8'h00, 32'hff, RESP_SLVERR);
    chk("irq", 32'h0, 32'(irq));
    $display("test reset done");
  endtask
  task automatic t_dlink;
    pulse(13'h001, 1);
    chk("irq", 32'h0, 32'(irq));
    wc(ADDR_DL_CLR, 32'h7f);
    wc(ADDR_IRQ_EN, 32'h04);
    pulse(13'h001, 1);
    chk("irq", 32'h1, 32'(irq));
    wc(ADDR_DL_CLR, 32'h04);
    chk("irq", 32'h0, 32'(irq));
    wc(ADDR_IRQ_EN, 32'h03);
    rc(ADDR_IRQ_EN, 32'h03);
    bits(8'h7e);
    chk("irq", 32'h1, 32'(irq));
    rc(ADDR_DL_STAT, 32'h01);
    bits(8'hfe);
    rc(ADDR_DL_STAT, 32'h03);
    wc(ADDR_DL_CLR, 32'h03);
    chk("irq", 32'h0, 32'(irq));
    wc(ADDR_IRQ_EN, 32'h40);
    pulse(13'h01e, 1);
    chk("irq", 32'h1, 32'(irq));
    rc(ADDR_DL_STAT, 32'h78);
    wc(ADDR_DL_CLR, 32'h78);
    chk("irq", 32'h0, 32'(irq));
    $display("test data link done");
  endtask
  task automatic t_sig;
    wc(ADDR_SIG_EN, 32'h02);
    rc(ADDR_SIG_EN, 32'h02);
    pulse(13'h600, 3);
    rc(ADDR_SIG_STAT, 32'h0);
    pulse(13'h600, 1);
    chk("irq", 32'h1, 32'(irq));
    rc(ADDR_SIG_STAT, 32'h02);
    chk("irq", 32'h0, 32'(irq));
    rc(ADDR_SIG_STAT, 32'h0);
    wc(ADDR_CFG, 32'h01);
    rc(ADDR_CFG, 32'h01);
    pulse(13'h600, 7);
    rc(ADDR_SIG_STAT, 32'h0);
    wc(ADDR_SIG_EN, 32'h0);
    pulse(13'h600, 1);
    chk("irq", 32'h0, 32'(irq));
    rc(ADDR_SIG_STAT, 32'h02);
    pulse(13'h800, 1);
    pulse(13'h1000, 10);
    rc(ADDR_SIG_STAT, 32'h0);
    wc(ADDR_SIG_EN, 32'h01);
    pulse(13'h1000, 1);
    chk("irq", 32'h1, 32'(irq));
    rc(ADDR_SIG_STAT, 32'h01);
    pulse(13'h1e0, 1);
    rc(ADDR_SIG_STAT, 32'h3c);
    pulse(13'h1e0, 1);
    wc(ADDR_SIG_STAT, 32'h0);
    rc(ADDR_SIG_STAT, 32'h0);
    $display("test signalling done");
  endtask
  // reset in mid-run drops the interrupt, the interrupt enable and the data link status
  task automatic t_rst2;
    wc(ADDR_IRQ_EN, 32'h04);
    pulse(13'h001, 1);
    chk("irq", 32'h1, 32'(irq));
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("irq", 32'h0, 32'(irq));
    rc(ADDR_IRQ_EN, 32'h0);
    rc(ADDR_DL_STAT, 32'h0);
    $display("test mid-run reset done");
  endtask
  initial begin
    aresetn <= 1'b0;
    ev <= '0;
    dl_rx_bit <= 1'b0;
    dl_rx_bit_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_dlink;
    t_sig;
    t_rst2;
    summarize;
  end
endmodule
`default_nettype wire
